// ### include/pwr_pkg.sv
// shared constants and types for the power mode controller
package pwr_pkg;
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_MODE     = 8'h04;
	localparam logic [7:0] OFF_RETAIN   = 8'h08;
	localparam logic [7:0] OFF_WAKECFG  = 8'h0c;
	localparam logic [7:0] OFF_STATUS   = 8'h10;
	localparam logic [7:0] OFF_EVENTS   = 8'h14;
	localparam logic [7:0] OFF_INTMASK  = 8'h18;
	localparam logic [7:0] OFF_SUPPLY   = 8'h1c;
	localparam int         NUM_BLOCKS   = 2;
	localparam int         NUM_FUNC     = 8;
	localparam logic [31:0] CMD_OFF     = 32'h00000001;
	// event bit positions
	localparam int EV_WAKE   = 0;
	localparam int EV_POR    = 1;
	localparam int EV_BOR    = 2;
	localparam int EV_PFAIL  = 3;
	localparam int NUM_EV    = 4;
	// reset sequence length and regulator and clock source startup times
	localparam int RST_SEQ_NS   = 100;
	localparam int CLK_NS       = 10;
	localparam int RST_SEQ_CYC  = (RST_SEQ_NS + CLK_NS - 1) / CLK_NS;
	localparam int T1V7_NS      = 200;
	localparam int T1V7_CYC     = (T1V7_NS + CLK_NS - 1) / CLK_NS;
	localparam int T1V2_NS      = 100;
	localparam int T1V2_CYC     = (T1V2_NS + CLK_NS - 1) / CLK_NS;
	localparam int TCLK_NS      = 50;
	localparam int TCLK_CYC     = (TCLK_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] CLK_HF_RC_OSCILLATOR = 2'h0;
	localparam logic [1:0] CLK_XO16 = 2'h1;
	localparam logic [1:0] CLK_XO32 = 2'h2;
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_ON    = 2'b01,
		ST_OFF   = 2'b10
	} pwr_state_e;
endpackage : pwr_pkg

// ### include/res_if.sv
// resource request and ready signals between controller and starter
`timescale 1ns/1ns
interface res_if;
	logic       req_1v7;
	logic       req_1v2;
	logic       req_clk;
	logic [1:0] clk_sel;
	logic       rdy_1v7;
	logic       rdy_1v2;
	logic       rdy_clk;
	modport ctrl (output req_1v7, req_1v2, req_clk, clk_sel, input rdy_1v7, rdy_1v2, rdy_clk);
	modport start (input req_1v7, req_1v2, req_clk, clk_sel, output rdy_1v7, rdy_1v2, rdy_clk);
endinterface : res_if

// ### hdl/res_starter.sv
// startup timers for regulators and clock source
`timescale 1ns/1ns
module res_starter (
	input  wire logic clk_i,    // clock
	input  wire logic rst_i,    // sync reset
	res_if.start      rif       // resource port
);
	import pwr_pkg::*;

	function automatic logic [7:0] step(input logic req, input logic [7:0] c, input int lim);
		if (!req)
			return 8'h00;
		else if (c < 8'(lim))
			return c + 8'h01;
		else
			return c;
	endfunction : step

	logic [7:0] c17_r;
	logic [7:0] c12_r;
	logic [7:0] cck_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c17_r <= 8'h00;
			c12_r <= 8'h00;
			cck_r <= 8'h00;
		end else begin
			c17_r <= step(rif.req_1v7, c17_r, T1V7_CYC);
			c12_r <= step(rif.req_1v2 && rif.rdy_1v7, c12_r, T1V2_CYC);
			cck_r <= step(rif.req_clk && rif.rdy_1v2, cck_r, TCLK_CYC);
		end
	end

	assign rif.rdy_1v7 = (c17_r == 8'(T1V7_CYC));
	assign rif.rdy_1v2 = (c12_r == 8'(T1V2_CYC));
	assign rif.rdy_clk = (cck_r == 8'(TCLK_CYC));
endmodule : res_starter

// ### hdl/power_mode_ctrl.sv
// power mode controller: system off/on, sub-modes, retention, supply control
// Summary of operation
// - off entry powers down core, aborts tasks
// - only pin and comparator wake logic responsive when off; here the wishbone registers and por/brownout reset also stay active
// - reset, pin detect, comparator detect wake
// - retain selected 8 kB RAM blocks
// - block is two 4 kB sections
// - each function idles or runs independently
// - low power: power down during sleep
// - cpu wake waits for 1V7 ready
// - tasks wait for needed resources
// - constant latency keeps base set on
// - base set: 1V7, 1V2, one clock
// - buck suspended between radio events
// - linear mode bypasses and disables buck
// - supervisor: por, brownout, power fail
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
module power_mode_ctrl (
	input  wire logic                          clk_i,           // clock
	input  wire logic                          rst_i,           // sync reset
	input  wire logic [7:0]                    wb_adr_i,        // wishbone address
	input  wire logic [31:0]                   wb_dat_i,        // write data
	output logic      [31:0]                   wb_dat_o,        // read data
	input  wire logic                          wb_we_i,         // write enable
	input  wire logic [3:0]                    wb_sel_i,        // byte selects
	input  wire logic                          wb_cyc_i,        // cycle
	input  wire logic                          wb_stb_i,        // strobe
	output logic                               wb_ack_o,        // acknowledge
	output logic                               irq_o,           // interrupt level
	input  wire logic                          pin_detect_i,    // pin level detect
	input  wire logic                          comparator_wake_detect_i, // comparator detect
	input  wire logic                          por_i,           // power-on detect
	input  wire logic                          brownout_i,      // brownout detect
	input  wire logic                          pfail_i,         // below fail threshold
	input  wire logic                          cpu_wake_req_i,  // cpu wants to run
	input  wire logic                          task_req_i,      // interconnect task pending
	input  wire logic                          radio_active_i,  // radio event in progress
	input  wire logic [pwr_pkg::NUM_FUNC-1:0]  func_need_i,     // per block function need
	output logic      [pwr_pkg::NUM_FUNC-1:0]  func_run_o,      // per block run
	output logic                               core_pwr_o,      // core power on
	output logic                               task_abort_o,    // abort all tasks pulse
	output logic                               sys_rst_o,       // system reset
	output logic                               cpu_run_o,       // cpu released
	output logic                               task_go_o,       // task may proceed
	output logic                               reg1v7_en_o,     // 1V7 regulator enable
	output logic                               reg1v2_en_o,     // 1V2 regulator enable
	output logic                               hf_rc_oscillator_en_o, // rc clock enable
	output logic                               hf_crystal_16_en_o,    // 16 MHz crystal
	output logic                               hf_crystal_32_en_o,    // 32 MHz crystal
	output logic                               buck_en_o,       // buck running
	output logic                               buck_bypass_o,   // buck bypassed
	output logic                               pin_wake_arm_o,  // pin wake armed
	output logic      [2*pwr_pkg::NUM_BLOCKS-1:0] sect_pwr_o,   // per 4 kB section power
	output logic      [2*pwr_pkg::NUM_BLOCKS-1:0] sect_ret_o    // per section retention
);
	import pwr_pkg::*;

	res_if rif();

	res_starter u_start (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.rif   (rif)
	);

	pwr_state_e         state_r;
	logic [7:0]         seq_cnt_r;
	logic               const_lat_r;
	logic [1:0]         clk_sel_r;
	logic [NUM_BLOCKS-1:0] retain_r;
	logic               wake_pin_en_r;
	logic               wake_cmp_en_r;
	logic               buck_cfg_r;
	logic [NUM_EV-1:0]  ev_r;
	logic [NUM_EV-1:0]  mask_r;
	logic [NUM_EV-1:0]  ev_set;
	logic               wb_req;
	logic               wr_go;
	logic               rd_ev;
	logic               wake_src;
	logic               go_off;
	logic               on_st;
	logic               need_res;
	logic [31:0]        rd_nxt;
	logic [31:0]        mode_w;
	logic               off_nxt;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : merge

	// one block bit drives both of its 4 kB sections
	function automatic logic [2*NUM_BLOCKS-1:0] both_sect(input logic [NUM_BLOCKS-1:0] blk);
		logic [2*NUM_BLOCKS-1:0] s;
		for (int b = 0; b < NUM_BLOCKS; b++)
			s[2*b +: 2] = {2{blk[b]}};
		return s;
	endfunction : both_sect

	assign mode_w  = merge({29'h0, clk_sel_r, const_lat_r}, wb_dat_i, wb_sel_i);
	assign off_nxt = (state_r == ST_OFF) || go_off;

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_go  = wb_req && wb_we_i;
	assign rd_ev  = wb_req && !wb_we_i && (wb_adr_i == OFF_EVENTS);
	assign on_st  = (state_r == ST_ON);
	assign go_off = on_st && wr_go && (wb_adr_i == OFF_CTRL) && wb_sel_i[0]
		&& (wb_dat_i[0] == CMD_OFF[0]);
	assign wake_src = (wake_pin_en_r && pin_detect_i)
		|| (wake_cmp_en_r && comparator_wake_detect_i);
	// sleep resources: held in constant latency, requested on demand otherwise
	assign need_res = on_st && (const_lat_r || cpu_wake_req_i || task_req_i);

	// power state machine
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i || brownout_i) begin
			state_r   <= ST_RESET;
			seq_cnt_r <= 8'h00;
		end else begin
			unique case (state_r)
				ST_RESET: begin
					if (seq_cnt_r == 8'(RST_SEQ_CYC - 1)) begin
						state_r <= ST_ON;
					end else begin
						seq_cnt_r <= seq_cnt_r + 8'h01;
					end
				end
				ST_ON: begin
					if (go_off) begin
						state_r <= ST_OFF;
					end
				end
				ST_OFF: begin
					if (wake_src) begin
						state_r   <= ST_RESET;
						seq_cnt_r <= 8'h00;
					end
				end
				default: begin
					state_r <= ST_RESET;
				end
			endcase
		end
	end

	// configuration registers; off-state wake enables survive the reset sequence
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			const_lat_r   <= 1'b0;
			clk_sel_r     <= CLK_HF_RC_OSCILLATOR;
			retain_r      <= '0;
			wake_pin_en_r <= 1'b0;
			wake_cmp_en_r <= 1'b0;
			buck_cfg_r    <= 1'b0;
			mask_r        <= '0;
		end else if (wr_go) begin
			unique case (wb_adr_i)
				OFF_MODE: begin
					const_lat_r <= mode_w[0];
					clk_sel_r   <= (mode_w[2:1] == 2'h3) ? clk_sel_r : mode_w[2:1];
				end
				OFF_RETAIN: begin
					if (wb_sel_i[0])
						retain_r <= wb_dat_i[NUM_BLOCKS-1:0];
				end
				OFF_WAKECFG: begin
					if (wb_sel_i[0]) begin
						wake_pin_en_r <= wb_dat_i[0];
						wake_cmp_en_r <= wb_dat_i[1];
					end
				end
				OFF_INTMASK: begin
					if (wb_sel_i[0])
						mask_r <= wb_dat_i[NUM_EV-1:0];
				end
				OFF_SUPPLY: begin
					if (wb_sel_i[0])
						buck_cfg_r <= wb_dat_i[0];
				end
				default: begin
				end
			endcase
		end
	end

	// sticky events, set wins over read-clear
	always_comb begin
		ev_set = '0;
		ev_set[EV_WAKE]  = (state_r == ST_OFF) && wake_src;
		ev_set[EV_POR]   = por_i;
		ev_set[EV_BOR]   = brownout_i;
		ev_set[EV_PFAIL] = pfail_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ev_r <= '0;
		end else begin
			ev_r <= (rd_ev ? '0 : ev_r) | ev_set;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(((rd_ev ? '0 : ev_r) | ev_set) & mask_r);
		end
	end

	// wishbone read data and single-cycle ack
	always_comb begin
		rd_nxt = 32'h0;
		unique case (wb_adr_i)
			OFF_CTRL:    rd_nxt = 32'h0;
			OFF_MODE:    rd_nxt = {29'h0, clk_sel_r, const_lat_r};
			OFF_RETAIN:  rd_nxt = {30'h0, retain_r};
			OFF_WAKECFG: rd_nxt = {30'h0, wake_cmp_en_r, wake_pin_en_r};
			OFF_STATUS:  rd_nxt = {26'h0, rif.rdy_clk, rif.rdy_1v2, rif.rdy_1v7, pfail_i,
				state_r};
			OFF_EVENTS:  rd_nxt = {28'h0, ev_r};
			OFF_INTMASK: rd_nxt = {28'h0, mask_r};
			OFF_SUPPLY:  rd_nxt = {31'h0, buck_cfg_r};
			default:     rd_nxt = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= (wb_req && !wb_we_i) ? rd_nxt : 32'h0;
		end
	end

	assign rif.req_1v7 = need_res;
	assign rif.req_1v2 = need_res && (const_lat_r || task_req_i);
	assign rif.req_clk = need_res && (const_lat_r || task_req_i);
	assign rif.clk_sel = clk_sel_r;

	// outputs toward cpu, peripherals, regulators, oscillators and ram
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			func_run_o            <= '0;
			core_pwr_o            <= 1'b0;
			task_abort_o          <= 1'b0;
			sys_rst_o             <= 1'b1;
			cpu_run_o             <= 1'b0;
			task_go_o             <= 1'b0;
			reg1v7_en_o           <= 1'b0;
			reg1v2_en_o           <= 1'b0;
			hf_rc_oscillator_en_o <= 1'b0;
			hf_crystal_16_en_o    <= 1'b0;
			hf_crystal_32_en_o    <= 1'b0;
			buck_en_o             <= 1'b0;
			buck_bypass_o         <= 1'b1;
			pin_wake_arm_o        <= 1'b0;
			sect_pwr_o            <= '0;
			sect_ret_o            <= '0;
		end else begin
			func_run_o     <= on_st ? func_need_i : '0;
			core_pwr_o     <= (state_r != ST_OFF) && !go_off;
			task_abort_o   <= go_off;
			sys_rst_o      <= (state_r == ST_RESET);
			cpu_run_o      <= on_st && cpu_wake_req_i && rif.rdy_1v7;
			task_go_o      <= on_st && task_req_i && rif.rdy_1v7 && rif.rdy_1v2
				&& rif.rdy_clk;
			reg1v7_en_o    <= rif.req_1v7;
			reg1v2_en_o    <= rif.req_1v2;
			hf_rc_oscillator_en_o <= rif.req_clk && (clk_sel_r == CLK_HF_RC_OSCILLATOR);
			hf_crystal_16_en_o    <= rif.req_clk && (clk_sel_r == CLK_XO16);
			hf_crystal_32_en_o    <= rif.req_clk && (clk_sel_r == CLK_XO32);
			buck_en_o      <= buck_cfg_r && on_st && radio_active_i;
			buck_bypass_o  <= !buck_cfg_r;
			pin_wake_arm_o <= (state_r == ST_OFF) || go_off;
			sect_pwr_o     <= both_sect(retain_r | {NUM_BLOCKS{!off_nxt}});
			sect_ret_o     <= both_sect(retain_r & {NUM_BLOCKS{off_nxt}});
		end
	end

	a_cpu_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		cpu_run_o |-> $past(rif.rdy_1v7))
		else $error("cpu released before 1V7 ready");
	a_task_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		task_go_o |-> $past(rif.rdy_1v2 && rif.rdy_clk))
		else $error("task released before resources ready");
	a_off_abort: assert property (@(posedge clk_i) disable iff (rst_i)
		go_off |=> task_abort_o && !core_pwr_o)
		else $error("off entry did not abort and power down");
	a_wake_reset: assert property (@(posedge clk_i) disable iff (rst_i || por_i || brownout_i)
		(state_r == ST_OFF && wake_src) |=> ##1 sys_rst_o)
		else $error("wake did not start reset sequence");
	a_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		($past(state_r) == ST_OFF && state_r == ST_OFF) |-> !cpu_run_o && func_run_o == '0)
		else $error("activity while off");
	a_bypass_sel: assert property (@(posedge clk_i) disable iff (rst_i)
		!buck_cfg_r |=> buck_bypass_o && !buck_en_o)
		else $error("buck not bypassed in linear mode");
	a_const_base: assert property (@(posedge clk_i) disable iff (rst_i)
		(on_st && const_lat_r) |=> reg1v7_en_o && reg1v2_en_o)
		else $error("base set dropped in constant latency");
	a_one_clock: assert property (@(posedge clk_i) disable iff (rst_i)
		$onehot0({hf_rc_oscillator_en_o, hf_crystal_16_en_o, hf_crystal_32_en_o}))
		else $error("more than one clock source on");
	a_retain_kept: assert property (@(posedge clk_i) disable iff (rst_i)
		($past(state_r) == ST_OFF && state_r == ST_OFF)
		|-> sect_pwr_o == both_sect($past(retain_r)) && sect_ret_o == both_sect($past(retain_r)))
		else $error("retention power wrong");
endmodule : power_mode_ctrl

// ### tb/req_partner.sv
// cpu and peripheral side: wake and task requests toward the controller
`timescale 1ns/1ns
module req_partner (
	input  wire logic clk_i,          // clock
	input  wire logic rst_i,          // sync reset
	input  wire logic want_cpu_i,     // bench wants cpu running
	input  wire logic want_task_i,    // bench posts a task
	input  wire logic task_go_i,      // controller grants task
	output logic      cpu_wake_req_o, // cpu wake level
	output logic      task_req_o      // task pending level
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_wake_req_o <= 1'b0;
			task_req_o     <= 1'b0;
		end else begin
			cpu_wake_req_o <= want_cpu_i;
			// task held until granted
			if (task_go_i)
				task_req_o <= 1'b0;
			else if (want_task_i)
				task_req_o <= 1'b1;
		end
	end
endmodule : req_partner

// ### tb/tb.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ns
module tb;
	import pwr_pkg::*;
	logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq_o;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [3:0] wb_sel_i, sect_pwr_o, sect_ret_o;
	logic pin_detect_i, comp_i, por_i, brownout_i, pfail_i, radio_active_i;
	logic cpu_req, task_req, want_cpu, want_task;
	logic [NUM_FUNC-1:0] func_need_i, func_run_o;
	logic core_pwr_o, task_abort_o, sys_rst_o, cpu_run_o, task_go_o, r17, r12;
	logic rc_o, x16_o, x32_o, buck_en_o, buck_bypass_o, arm_o;
	logic [1:0] rv;
	int bad_count, comparisons, n, abort_n, a0, seed;
	power_mode_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
		.pin_detect_i(pin_detect_i), .comparator_wake_detect_i(comp_i), .por_i(por_i),
		.brownout_i(brownout_i), .pfail_i(pfail_i), .cpu_wake_req_i(cpu_req),
		.task_req_i(task_req), .radio_active_i(radio_active_i), .func_need_i(func_need_i),
		.func_run_o(func_run_o), .core_pwr_o(core_pwr_o), .task_abort_o(task_abort_o),
		.sys_rst_o(sys_rst_o), .cpu_run_o(cpu_run_o), .task_go_o(task_go_o),
		.reg1v7_en_o(r17), .reg1v2_en_o(r12), .hf_rc_oscillator_en_o(rc_o),
		.hf_crystal_16_en_o(x16_o), .hf_crystal_32_en_o(x32_o), .buck_en_o(buck_en_o),
		.buck_bypass_o(buck_bypass_o), .pin_wake_arm_o(arm_o), .sect_pwr_o(sect_pwr_o),
		.sect_ret_o(sect_ret_o));
	req_partner partner (.clk_i(clk_i), .rst_i(rst_i), .want_cpu_i(want_cpu),
		.want_task_i(want_task), .task_go_i(task_go_o), .cpu_wake_req_o(cpu_req),
		.task_req_o(task_req));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) if (task_abort_o === 1'b1) abort_n++;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s seen %h exp %h", $time, m, seen, exp);
		end
	endtask : chk
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		int k;
		k = 0;
		wb_adr_i <= a; wb_we_i <= w; wb_dat_i <= d; wb_sel_i <= 4'hf;
		wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1;
		do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 50);
		if (k >= 50) chk(32'h0, 32'h1, "no ack");
		r = wb_dat_o;
		wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(a, 1'b1, d, r);
	endtask : wr
	function automatic logic sig(input int w);
		case (w)
			0: return sys_rst_o;
			1: return core_pwr_o;
			2: return cpu_run_o;
			default: return task_go_o;
		endcase
	endfunction : sig
	task automatic wait_sig(input int w, input logic lv, output int k);
		k = 0;
		while (sig(w) !== lv && k < 300) begin @(posedge clk_i); k++; end
		if (k >= 300) chk(w, 32'hff, "wait");
	endtask : wait_sig
	task automatic report_and_stop();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		report_and_stop();
	end
	initial begin
		seed = 45374;
		rst_i = 1'b1; wb_adr_i = 8'h00; wb_dat_i = 32'h0; wb_we_i = 1'b0; wb_sel_i = 4'h0;
		wb_cyc_i = 1'b0; wb_stb_i = 1'b0; pin_detect_i = 1'b0; comp_i = 1'b0; por_i = 1'b0;
		brownout_i = 1'b0; pfail_i = 1'b0; radio_active_i = 1'b0; func_need_i = '0;
		want_cpu = 1'b0; want_task = 1'b0;
		repeat (5) @(posedge clk_i);
		chk({sys_rst_o, buck_bypass_o, core_pwr_o}, 3'b110, "in reset");
		rst_i <= 1'b0;
		wait_sig(0, 1'b0, n);
		chk(n >= RST_SEQ_CYC && n <= RST_SEQ_CYC + 2, 1, "reset length");
		wb(OFF_STATUS, 1'b0, 0, q);
		chk(q[1:0], ST_ON, "state on");
		wb(8'h20, 1'b0, 0, q);
		chk(q, 0, "unmapped");
		for (int i = 0; i < 16; i++) begin
			func_need_i <= 8'($random(seed));
			repeat (3) @(posedge clk_i);
			chk(func_run_o, func_need_i, "func run");
		end
		wr(OFF_SUPPLY, 1);
		for (int r = 0; r < 2; r++) begin
			radio_active_i <= r[0];
			repeat (4) @(posedge clk_i);
			chk({buck_en_o, buck_bypass_o}, {r[0], 1'b0}, "buck auto");
		end
		wr(OFF_SUPPLY, 0);
		repeat (4) @(posedge clk_i);
		chk({buck_en_o, buck_bypass_o}, 2'b01, "linear");
		for (int c = 0; c < 3; c++) begin
			wr(OFF_MODE, (c << 1) | 1);
			repeat (40) @(posedge clk_i);
			chk({r17, r12, x32_o, x16_o, rc_o}, {2'b11, 3'(1 << c)}, "base set");
		end
		want_cpu <= 1'b1;
		wait_sig(2, 1'b1, n);
		chk(n < T1V7_CYC, 1, "const latency");
		want_cpu <= 1'b0;
		wr(OFF_MODE, 0);
		repeat (40) @(posedge clk_i);
		chk({r12, x32_o, x16_o, rc_o}, 0, "low power sleep");
		want_cpu <= 1'b1;
		wait_sig(2, 1'b1, n);
		chk(n >= T1V7_CYC, 1, "cpu waits 1v7");
		want_cpu <= 1'b0;
		repeat (30) @(posedge clk_i);
		want_task <= 1'b1;
		wait_sig(3, 1'b1, n);
		want_task <= 1'b0;
		chk(n >= T1V7_CYC + T1V2_CYC + TCLK_CYC, 1, "task waits");
		for (int m = 1; m >= 0; m--) begin
			wr(OFF_INTMASK, m << EV_PFAIL);
			pfail_i <= 1'b1;
			repeat (4) @(posedge clk_i);
			pfail_i <= 1'b0;
			chk(irq_o, m[0], "irq mask");
			wb(OFF_EVENTS, 1'b0, 0, q);
			chk(q[3:0], 4'h1 << EV_PFAIL, "pfail event");
			repeat (3) @(posedge clk_i);
			chk(irq_o, 1'b0, "irq cleared");
		end
		for (int s = 0; s < 2; s++) begin
			rv = 2'($random(seed));
			wr(OFF_RETAIN, rv);
			wr(OFF_WAKECFG, 1 << s);
			a0 = abort_n;
			wr(OFF_CTRL, CMD_OFF);
			wait_sig(1, 1'b0, n);
			repeat (3) @(posedge clk_i);
			chk(abort_n, a0 + 1, "abort pulse");
			chk(cpu_run_o, 1'b0, "cpu down");
			chk(sect_ret_o, {{2{rv[1]}}, {2{rv[0]}}}, "retention");
			chk({arm_o, sect_pwr_o}, {1'b1, rv[1], rv[1], rv[0], rv[0]}, "off power");
			if (s == 0) comp_i <= 1'b1; else pin_detect_i <= 1'b1;
			repeat (20) @(posedge clk_i);
			chk(core_pwr_o, 1'b0, "other source");
			comp_i <= (s == 1); pin_detect_i <= (s == 0);
			wait_sig(0, 1'b1, n);
			comp_i <= 1'b0; pin_detect_i <= 1'b0;
			wait_sig(0, 1'b0, n);
			chk(core_pwr_o, 1'b1, "woken");
			chk({arm_o, sect_pwr_o}, 5'h0f, "on power");
			wb(OFF_EVENTS, 1'b0, 0, q);
			chk(q[3:0], 4'h1 << EV_WAKE, "wake event");
		end
		for (int p = 0; p < 2; p++) begin
			if (p == 0)
				por_i <= 1'b1;
			else
				brownout_i <= 1'b1;
			repeat (3) @(posedge clk_i);
			chk({sys_rst_o, cpu_run_o}, 2'b10, "supervisor reset");
			por_i <= 1'b0;
			brownout_i <= 1'b0;
			wait_sig(0, 1'b0, n);
			chk(n >= RST_SEQ_CYC && n <= RST_SEQ_CYC + 2, 1, "supervisor restart");
			wb(OFF_EVENTS, 1'b0, 0, q);
			chk(q[3:0], 4'h1 << (EV_POR + p), "supervisor event");
		end
		report_and_stop();
	end
endmodule : tb
